// File: design/bsfm_pkg.sv
/*
 * constants for the bank-select load and file-to-file move executor.
 * assumes a core that delivers 16-bit instruction words with a Q1 strobe
 * and owns a byte-wide data memory port outside this block.
 */
package bsfm_pkg;
	localparam logic [7:0]  OPC_BANK_LOAD   = 8'h01;
	localparam logic [3:0]  OPC_MOVE_FIRST  = 4'hc;
	localparam logic [3:0]  OPC_MOVE_SECOND = 4'hf;
	localparam logic [7:0]  BANK_RESET      = 8'h00;
	localparam logic [7:0]  BANK_KEEP_MASK  = 8'h0f;
	localparam int          ADDR_W          = 12;

	// position in the four-phase instruction cycle
	typedef enum logic [1:0] {
		BSFM_Q1,
		BSFM_Q2,
		BSFM_Q3,
		BSFM_Q4
	} bsfm_phase_e;

	// executor state across instruction cycles
	typedef enum logic [1:0] {
		BSFM_IDLE,
		BSFM_MOVE_WAIT,
		BSFM_MOVE_SECOND
	} bsfm_state_e;
endpackage : bsfm_pkg

// File: design/bsfm_exec.sv
/*
 * executor for the bank-select literal load and the two-word file move.
 * assumes instr_word is stable from Q1 to Q4 of each cycle, that q1_start
 * pulses on the clock of Q1, and that mem_rdata is valid in the cycle after
 * mem_rd is asserted.
 */
module bsfm_exec (
	input  wire logic                       clk_sys,
	input  wire logic                       reset,
	input  wire logic                       q1_start,
	input  wire logic [15:0]                instr_word,
	input  wire logic [7:0]                 mem_rdata,
	output logic      [7:0]                 bank_select_register,
	output logic                            mem_rd,
	output logic                            mem_wr,
	output logic      [bsfm_pkg::ADDR_W-1:0] mem_addr,
	output logic      [7:0]                 mem_wdata,
	output logic                            flags_we,
	output logic                            move_busy
);
	// ************************************************************
	// phase counter
	// ************************************************************
	bsfm_pkg::bsfm_phase_e phase_q, phase_d;

	// q1_start resynchronises the phase; any strobe, stray or not, restarts the count at Q2
	always_comb begin
		if (q1_start) begin
			phase_d = bsfm_pkg::BSFM_Q2;
		end else begin
			unique case (phase_q)
				bsfm_pkg::BSFM_Q1: phase_d = bsfm_pkg::BSFM_Q2;
				bsfm_pkg::BSFM_Q2: phase_d = bsfm_pkg::BSFM_Q3;
				bsfm_pkg::BSFM_Q3: phase_d = bsfm_pkg::BSFM_Q4;
				bsfm_pkg::BSFM_Q4: phase_d = bsfm_pkg::BSFM_Q1;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) phase_q <= bsfm_pkg::BSFM_Q4;
		else phase_q <= phase_d;
	end

	// ************************************************************
	// decode
	// ************************************************************
	logic is_bank_load;
	logic is_move_first;
	logic is_move_second;

	assign is_bank_load   = (instr_word[15:8] == bsfm_pkg::OPC_BANK_LOAD);
	assign is_move_first  = (instr_word[15:12] == bsfm_pkg::OPC_MOVE_FIRST);
	assign is_move_second = (instr_word[15:12] == bsfm_pkg::OPC_MOVE_SECOND);

	// ************************************************************
	// execution state
	// ************************************************************
	bsfm_pkg::bsfm_state_e state_q, state_d;
	logic [7:0]                  bank_q, bank_d;
	logic [7:0]                  hold_q, hold_d;
	logic [7:0]                  lit_q, lit_d;
	logic                        bank_pend_q, bank_pend_d;
	logic                        rd_q, rd_d;
	logic                        wr_q, wr_d;
	logic [bsfm_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic [7:0]                  wdata_q, wdata_d;

	// the phase shown combinationally is the one being executed this cycle
	logic in_q1;
	logic in_q2;
	logic in_q3;
	logic in_q4;
	assign in_q1 = q1_start;
	assign in_q2 = !q1_start && phase_q == bsfm_pkg::BSFM_Q2;
	assign in_q3 = !q1_start && phase_q == bsfm_pkg::BSFM_Q3;
	assign in_q4 = !q1_start && phase_q == bsfm_pkg::BSFM_Q4;

	// one next-state block; memory strobes are registered one clock late
	always_comb begin
		state_d     = state_q;
		bank_d      = bank_q;
		hold_d      = hold_q;
		lit_d       = lit_q;
		bank_pend_d = bank_pend_q;
		rd_d        = 1'b0;
		wr_d        = 1'b0;
		addr_d      = addr_q;
		wdata_d     = wdata_q;
		unique case (state_q)
			bsfm_pkg::BSFM_IDLE: begin
				if (in_q1 && is_bank_load) begin
					bank_pend_d = 1'b1;
				end
				// first word of a move: the registered read shows in Q2
				if (in_q1 && is_move_first) begin
					state_d = bsfm_pkg::BSFM_MOVE_WAIT;
					rd_d    = 1'b1;
					addr_d  = instr_word[11:0];
				end
			end
			bsfm_pkg::BSFM_MOVE_WAIT: begin
				// source byte is captured below; Q4 of this cycle moves on to the second word
				if (in_q4) begin
					state_d = bsfm_pkg::BSFM_MOVE_SECOND;
				end
			end
			bsfm_pkg::BSFM_MOVE_SECOND: begin
				// second word: no read issued anywhere in this cycle
				if (in_q3 && is_move_second) begin
					wr_d    = 1'b1;
					addr_d  = instr_word[11:0];
					wdata_d = hold_q;
				end
				if (in_q4) begin
					state_d = bsfm_pkg::BSFM_IDLE;
				end
			end
			default: state_d = bsfm_pkg::BSFM_IDLE;
		endcase
		// source byte arrives in Q3 and is held in place for the write
		if (state_q == bsfm_pkg::BSFM_MOVE_WAIT && in_q3) begin
			hold_d = mem_rdata;
		end
		// literal read in Q2, written in Q4
		if (bank_pend_q && in_q2) begin
			lit_d = instr_word[7:0];
		end
		if (bank_pend_q && in_q4) begin
			bank_d      = lit_q & bsfm_pkg::BANK_KEEP_MASK;
			bank_pend_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q     <= bsfm_pkg::BSFM_IDLE;
			bank_q      <= bsfm_pkg::BANK_RESET;
			hold_q      <= 8'h00;
			lit_q       <= 8'h00;
			bank_pend_q <= 1'b0;
			rd_q        <= 1'b0;
			wr_q        <= 1'b0;
			addr_q      <= '0;
			wdata_q     <= 8'h00;
		end else begin
			state_q     <= state_d;
			bank_q      <= bank_d;
			hold_q      <= hold_d;
			lit_q       <= lit_d;
			bank_pend_q <= bank_pend_d;
			rd_q        <= rd_d;
			wr_q        <= wr_d;
			addr_q      <= addr_d;
			wdata_q     <= wdata_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign bank_select_register = bank_q;
	assign mem_rd               = rd_q;
	assign mem_wr               = wr_q;
	assign mem_addr             = addr_q;
	assign mem_wdata            = wdata_q;
	assign flags_we             = 1'b0;
	assign move_busy            = (state_q != bsfm_pkg::BSFM_IDLE);

	// ************************************************************
	// checks
	// ************************************************************
	bank_nibble_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
		bank_select_register[7:4] == 4'h0)
		else $error("bank register upper nibble not zero");

	bank_load_q4_a: assert property (@(posedge clk_sys) disable iff (reset)
		(in_q1 && is_bank_load && state_q == bsfm_pkg::BSFM_IDLE)
		|-> ##4 (bank_select_register == ($past(instr_word[7:0], 4) & bsfm_pkg::BANK_KEEP_MASK)))
		else $error("bank load literal not written by Q4");

	bank_one_cycle_a: assert property (@(posedge clk_sys) disable iff (reset)
		(in_q1 && is_bank_load && state_q == bsfm_pkg::BSFM_IDLE) |-> ##4 !bank_pend_q)
		else $error("bank load took longer than one cycle");

	no_flags_a: assert property (@(posedge clk_sys) disable iff (reset)
		!flags_we)
		else $error("flags written");

	move_read_q2_a: assert property (@(posedge clk_sys) disable iff (reset)
		mem_rd |-> (phase_q == bsfm_pkg::BSFM_Q2 && state_q == bsfm_pkg::BSFM_MOVE_WAIT))
		else $error("source read outside Q2 of move cycle one");

	no_second_read_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state_q == bsfm_pkg::BSFM_MOVE_SECOND) |-> !mem_rd)
		else $error("read during move cycle two");

	move_write_q4_a: assert property (@(posedge clk_sys) disable iff (reset)
		mem_wr |-> (phase_q == bsfm_pkg::BSFM_Q4 && mem_wdata == hold_q
		&& state_q == bsfm_pkg::BSFM_MOVE_SECOND))
		else $error("move write not in Q4 or wrong data");

	move_sequence_a: assert property (@(posedge clk_sys) disable iff (reset)
		(in_q1 && is_move_first && state_q == bsfm_pkg::BSFM_IDLE)
		|=> state_q == bsfm_pkg::BSFM_MOVE_WAIT)
		else $error("move first word not taken");

	move_read_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
		mem_rd |-> (mem_addr == $past(instr_word[11:0])))
		else $error("source read at wrong address");

	move_write_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
		mem_wr |-> (mem_addr == $past(instr_word[11:0])))
		else $error("move write at wrong address");

	move_two_cycles_a: assert property (@(posedge clk_sys) disable iff (reset)
		(in_q1 && is_move_first && state_q == bsfm_pkg::BSFM_IDLE) |-> ##8 !move_busy)
		else $error("move did not finish in two cycles");

	bank_q4_only_a: assert property (@(posedge clk_sys) disable iff (reset)
		!$stable(bank_select_register) |-> ($past(phase_q) == bsfm_pkg::BSFM_Q4))
		else $error("bank register changed outside Q4");
endmodule : bsfm_exec

// File: dv/tb_bsfm_exec.sv
/*
 * self-checking bench for bsfm_exec: bank literal loads and two-word moves.
 * assumes one clock domain and that the bench plays the core and data memory.
 */
module tb_bsfm_exec;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************
	// signals and dut
	// ****************
	logic                        clk_sys;
	logic                        reset;
	logic                        q1_start;
	logic [15:0]                 instr_word;
	logic [7:0]                  mem_rdata;
	logic [7:0]                  bank_select_register;
	logic                        mem_rd;
	logic                        mem_wr;
	logic [bsfm_pkg::ADDR_W-1:0] mem_addr;
	logic [7:0]                  mem_wdata;
	logic                        flags_we;
	logic                        move_busy;
	int                          n_mismatch = 0;
	int                          n_tests    = 0;
	int                          n_cyc      = 0;

	bsfm_exec uut (
		.clk_sys             (clk_sys),
		.reset               (reset),
		.q1_start            (q1_start),
		.instr_word          (instr_word),
		.mem_rdata           (mem_rdata),
		.bank_select_register(bank_select_register),
		.mem_rd              (mem_rd),
		.mem_wr              (mem_wr),
		.mem_addr            (mem_addr),
		.mem_wdata           (mem_wdata),
		.flags_we            (flags_we),
		.move_busy           (move_busy)
	);

	// 100 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ceiling far above the ~62 cycles the sequence needs
	always @(posedge clk_sys) begin
		n_cyc++;
		if (n_cyc == 2000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ****************
	// shared tasks
	// ****************
	// drive and sample 1 ns after the edge so NBA updates have landed
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask : tick

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	// ****************
	// scenarios
	// ****************
	// eight reset cycles, then one quiet edge before any instruction
	task automatic do_reset;
		reset = 1'b1;
		repeat (8) tick();
		reset = 1'b0;
		tick();
		check(16'(bank_select_register), 16'h0000);
		check(16'({mem_rd, mem_wr, move_busy}), 16'h0000);
	endtask : do_reset

	// one instruction cycle; the old bank value must hold until Q4
	task automatic bank_load(input logic [7:0] hi, input logic [7:0] lit, input logic [7:0] exp);
		logic [7:0] old;
		old        = bank_select_register;
		q1_start   = 1'b1;
		instr_word = {hi, lit};
		tick();
		q1_start = 1'b0;
		check(16'(flags_we), 16'h0000);
		tick();
		check(16'(bank_select_register), 16'(old));
		repeat (2) tick();
		check(16'(bank_select_register), 16'(exp));
	endtask : bank_load

	// two words; memory shows the byte only in Q3 so a late sample is caught
	task automatic do_move(input logic [11:0] src, input logic [11:0] dst, input logic [7:0] b,
			input logic [3:0] tag, input int exp_wr);
		int n_rd;
		int n_wr;
		n_rd       = 0;
		n_wr       = 0;
		q1_start   = 1'b1;
		instr_word = {bsfm_pkg::OPC_MOVE_FIRST, src};
		mem_rdata  = ~b;
		for (int k = 0; k < 8; k++) begin
			tick();
			// last pass leaves the pins to the next scenario's first drive
			if (k < 7) begin
				q1_start  = (k == 3);
				mem_rdata = (k == 1) ? b : ~b;
			end
			if (k == 3) begin
				instr_word = {tag, dst};
				check(16'(move_busy), 16'h0001);
			end
			if (mem_rd) begin
				n_rd++;
				check(16'(k), 16'h0000);
				check(16'(mem_addr), 16'(src));
			end
			if (mem_wr) begin
				n_wr++;
				check(16'(k), 16'h0006);
				check(16'(mem_addr), 16'(dst));
				check(16'(mem_wdata), 16'(b));
			end
			check(16'(flags_we), 16'h0000);
		end
		check(16'(n_rd), 16'h0001);
		check(16'(n_wr), 16'(exp_wr));
	endtask : do_move

	// ****************
	// main sequence
	// ****************
	initial begin
		q1_start   = 1'b0;
		instr_word = 16'h0000;
		mem_rdata  = 8'h00;
		do_reset();
		bank_load(bsfm_pkg::OPC_BANK_LOAD, 8'hff, 8'h0f);
		bank_load(bsfm_pkg::OPC_BANK_LOAD, 8'h05, 8'h05);
		bank_load(bsfm_pkg::OPC_BANK_LOAD, 8'ha3, 8'h03);
		bank_load(8'h02, 8'h77, 8'h03);
		do_move(12'h123, 12'h456, 8'h33, bsfm_pkg::OPC_MOVE_SECOND, 1);
		do_move(12'hfff, 12'h000, 8'hc5, bsfm_pkg::OPC_MOVE_SECOND, 1);
		do_move(12'h010, 12'h020, 8'h5a, 4'h3, 0);
		bank_load(bsfm_pkg::OPC_BANK_LOAD, 8'h0c, 8'h0c);
		do_reset();
		give_verdict();
	end
endmodule : tb_bsfm_exec
